// ==== core/acq_pkg.sv ====
// Notes on behaviour
// - ADC resolution is 15, 16, 17 or 18 bits for 69, 118, 215, 411 us pulses.
// - Single-LED pulse mode drives only the red LED; IR stays dark.
// - Die temperature is converted only on a host command, never continuously.
// - Interrupt pin is active low, open drain: pulls low or releases.
// - Red and IR channels are pulsed one after the other, never together.
// - Gap between channel pulses is 358, 407, 505 or 696 us per pulse width.
// - Rising edge spacing is 427, 525, 720 or 1107 us per pulse width.
// - Sample FIFO holds up to 32 samples for burst reads.
// - Finished temperature conversion raises the temperature-done flag.
// - Temperature-done flag clears when the host reads the temperature result.
// - Almost-full flag rises when the stored count reaches the programmed level.
// - Almost-full flag clears once the host reads FIFO data.
// - After a read, the next sample lands at the write pointer, newest in FIFO; it is at the read pointer only once drained.
// - Temperature start bit clears itself when its single conversion finishes.
// - Temperature result is two's-complement whole degrees plus 0.0625 degree fraction.
package acq_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CLK_HZ = CLK_MHZ * 1000000;
	typedef int unsigned tab4_t [4];
	typedef int unsigned tab8_t [8];
	localparam tab4_t PW_US = '{69, 118, 215, 411};
	localparam tab4_t GAP_US = '{358, 407, 505, 696};
	localparam tab8_t SPS = '{50, 100, 200, 400, 800, 1000, 1600, 3200};

	// ----------------------------------------------------------------
	// Modes, widths, reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	localparam logic [2:0] MODE_DUAL = 3'h3;
	localparam logic [4:0] RES_BASE = 5'h0F;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam logic [5:0] FIFO_FULL = 6'h20;
	localparam int unsigned CNT_W = 24;

	typedef enum logic [1:0] {
		TEMP_IDLE = 2'b01,
		TEMP_BUSY = 2'b10
	} temp_fsm_t;

	typedef struct packed {
		logic chan;
		logic [17:0] value;
	} sample_t;

	typedef struct packed {
		logic [7:0] whole;
		logic [3:0] frac;
	} temp_t;

	typedef struct packed {
		logic [2:0] mode;
		logic [1:0] pw;
		logic [2:0] rate;
		logic [5:0] af_level;
	} acq_cfg_t;

	typedef struct packed {
		logic sample_rdy;
		logic almost_full;
		logic temp_done;
	} irq_t;

	typedef struct packed {
		temp_fsm_t tstate;
		logic [CNT_W-1:0] period_cnt;
		logic red;
		logic ir;
		logic [4:0] res;
		sample_t [FIFO_DEPTH-1:0] mem;
		logic [4:0] rd_ptr;
		logic [4:0] wr_ptr;
		logic [5:0] count;
		sample_t head;
		irq_t flags;
		logic int_oe;
		logic int_out;
		logic conv_start;
		temp_t temp;
		logic [2:0] req_sync;
		logic req_seen;
		logic ack;
	} core_state_t;

	typedef struct packed {
		sample_t hold;
		logic req;
		logic [2:0] ack_sync;
		logic ack_seen;
	} link_state_t;

	function automatic tab4_t pw_tab();
		tab4_t t;
		for (int i = 0; i < 4; i++) begin
			t[i] = PW_US[i] * CLK_MHZ;
		end
		return t;
	endfunction : pw_tab

	function automatic tab4_t space_tab();
		tab4_t t;
		for (int i = 0; i < 4; i++) begin
			t[i] = (PW_US[i] + GAP_US[i]) * CLK_MHZ;
		end
		return t;
	endfunction : space_tab

	function automatic tab8_t period_tab();
		tab8_t t;
		for (int i = 0; i < 8; i++) begin
			t[i] = CLK_HZ / SPS[i];
		end
		return t;
	endfunction : period_tab

endpackage : acq_pkg

// ==== core/optical_acquisition_sequencer.sv ====
`timescale 1ns/1ps
module optical_acquisition_sequencer
	import acq_pkg::*;
#(
	parameter tab8_t PERIOD_CYC = period_tab(),
	parameter tab4_t PW_CYC = pw_tab(),
	parameter tab4_t SPACE_CYC = space_tab()
) (
	input wire logic clk,
	input wire logic rstn,
	input wire acq_cfg_t cfg,
	input wire irq_t irq_en,
	input wire logic temp_start,
	input wire logic temp_read,
	input wire logic fifo_read,
	input wire logic temp_conv_done,
	input wire temp_t temp_conv_value,
	input wire logic adc_clk,
	input wire logic adc_valid,
	input wire sample_t adc_sample,
	output logic red_led_o,
	output logic ir_led_o,
	output logic [4:0] adc_res_o,
	output logic temp_busy_o,
	output logic temp_conv_start_o,
	output temp_t temp_o,
	output sample_t fifo_head_o,
	output logic [5:0] fifo_count_o,
	output irq_t flags_o,
	output logic intr_o,
	output logic intr_oe_o
);

	core_state_t st_reg;
	core_state_t st_next;
	link_state_t lk_reg;
	link_state_t lk_next;

	// ----------------------------------------------------------------
	// Core domain next state
	// ----------------------------------------------------------------
	logic active;
	logic dual;
	logic new_sample;
	logic pop;
	logic push_ok;
	logic [CNT_W-1:0] period_last;
	logic [CNT_W-1:0] pw_len;
	logic [CNT_W-1:0] ir_start;

	always_comb begin
		st_next = st_reg;
		active = (cfg.mode == MODE_SINGLE) || (cfg.mode == MODE_DUAL);
		dual = (cfg.mode == MODE_DUAL);
		period_last = CNT_W'(PERIOD_CYC[cfg.rate] - 1);
		pw_len = CNT_W'(PW_CYC[cfg.pw]);
		ir_start = CNT_W'(SPACE_CYC[cfg.pw]);

		// Resolution tracks the pulse width setting
		st_next.res = RES_BASE + {3'h0, cfg.pw};

		// Sample period timebase; red opens each period, IR follows at the spacing.
		// Host keeps spacing plus pulse inside the period by its rate choice.
		if (!active) begin
			st_next.period_cnt = '0;
			st_next.red = 1'b0;
			st_next.ir = 1'b0;
		end else begin
			if (st_reg.period_cnt >= period_last) begin
				st_next.period_cnt = '0;
			end else begin
				st_next.period_cnt = st_reg.period_cnt + CNT_W'(1);
			end
			st_next.red = (st_reg.period_cnt < pw_len);
			// IR rises pulse width plus gap after red rises
			st_next.ir = dual && (st_reg.period_cnt >= ir_start)
				&& (st_reg.period_cnt < ir_start + pw_len);
		end

		// Sample arrival from the link side; the third stage only counts when
		// it agrees with the second, so a metastable settle is never seen twice.
		st_next.req_sync = {st_reg.req_sync[1:0], lk_reg.req};
		if (st_reg.req_sync[1] == st_reg.req_sync[2]) begin
			st_next.req_seen = st_reg.req_sync[2];
		end
		new_sample = (st_reg.req_seen != st_reg.ack);
		if (new_sample) begin
			st_next.ack = ~st_reg.ack;
		end

		// Ring FIFO; a full FIFO drops the newest sample rather than the oldest
		pop = fifo_read && (st_reg.count != 6'h00);
		push_ok = new_sample && ((st_reg.count != FIFO_FULL) || pop);
		if (pop) begin
			st_next.rd_ptr = st_reg.rd_ptr + 5'h01;
		end
		if (push_ok) begin
			// Write pointer meets the read pointer once drained: newest is oldest
			st_next.mem[st_reg.wr_ptr] = lk_reg.hold;
			st_next.wr_ptr = st_reg.wr_ptr + 5'h01;
		end
		st_next.count = st_reg.count + {5'h00, push_ok} - {5'h00, pop};
		st_next.head = st_next.mem[st_next.rd_ptr];

		// Flags: a set in the same cycle as a clear wins
		if (fifo_read) begin
			st_next.flags.sample_rdy = 1'b0;
			st_next.flags.almost_full = 1'b0;
		end
		if (push_ok) begin
			st_next.flags.sample_rdy = 1'b1;
		end
		if (push_ok && (st_next.count >= cfg.af_level)) begin
			st_next.flags.almost_full = 1'b1;
		end
		if (temp_read) begin
			st_next.flags.temp_done = 1'b0;
		end

		// Temperature conversion runs once per host command
		st_next.conv_start = 1'b0;
		unique case (st_reg.tstate)
			TEMP_IDLE: begin
				if (temp_start) begin
					st_next.tstate = TEMP_BUSY;
					st_next.conv_start = 1'b1;
				end
			end
			TEMP_BUSY: begin
				if (temp_conv_done) begin
					st_next.temp = temp_conv_value;
					st_next.flags.temp_done = 1'b1;
					st_next.tstate = TEMP_IDLE;
				end
			end
			default: begin
				st_next.tstate = TEMP_IDLE;
			end
		endcase

		// Open-drain pin: data is always low, enable decides pull or release
		st_next.int_out = 1'b0;
		st_next.int_oe = |(st_next.flags & irq_en);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.tstate <= TEMP_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: hold one sample until the core acknowledges it
	// ----------------------------------------------------------------
	logic link_idle;

	always_comb begin
		lk_next = lk_reg;
		lk_next.ack_sync = {lk_reg.ack_sync[1:0], st_reg.ack};
		if (lk_reg.ack_sync[1] == lk_reg.ack_sync[2]) begin
			lk_next.ack_seen = lk_reg.ack_sync[2];
		end
		// While a sample is in flight a new one is lost; the crossing takes a
		// few core cycles, far below any sample spacing.
		link_idle = (lk_reg.req == lk_reg.ack_seen);
		if (adc_valid && link_idle) begin
			lk_next.hold = adc_sample;
			lk_next.req = ~lk_reg.req;
		end
	end

	always_ff @(posedge adc_clk or negedge rstn) begin
		if (!rstn) begin
			lk_reg <= '0;
		end else begin
			lk_reg <= lk_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign red_led_o = st_reg.red;
	assign ir_led_o = st_reg.ir;
	assign adc_res_o = st_reg.res;
	assign temp_busy_o = st_reg.tstate[1];
	assign temp_conv_start_o = st_reg.conv_start;
	assign temp_o = st_reg.temp;
	assign fifo_head_o = st_reg.head;
	assign fifo_count_o = st_reg.count;
	assign flags_o = st_reg.flags;
	assign intr_o = st_reg.int_out;
	assign intr_oe_o = st_reg.int_oe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_res_follow: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> (adc_res_o == RES_BASE + {3'h0, $past(cfg.pw)}))
		else $error("resolution does not follow pulse width");

	a_single_red_only: assert property (@(posedge clk) disable iff (!rstn)
		($past(cfg.mode) != MODE_DUAL) |-> !ir_led_o)
		else $error("IR LED lit outside dual mode");

	a_leds_apart: assert property (@(posedge clk) disable iff (!rstn)
		!(red_led_o && ir_led_o))
		else $error("red and IR lit together");

	a_ir_spacing: assert property (@(posedge clk) disable iff (!rstn)
		$rose(ir_led_o) && $stable(cfg) |->
			($past(st_reg.period_cnt) == CNT_W'(SPACE_CYC[cfg.pw])))
		else $error("IR rising edge at wrong spacing");

	a_temp_on_cmd: assert property (@(posedge clk) disable iff (!rstn)
		temp_conv_start_o |-> ($past(temp_start) && temp_busy_o))
		else $error("temperature conversion without command");

	a_temp_done: assert property (@(posedge clk) disable iff (!rstn)
		temp_busy_o && temp_conv_done |=> flags_o.temp_done && !temp_busy_o)
		else $error("finished conversion not flagged");

	a_temp_clear: assert property (@(posedge clk) disable iff (!rstn)
		temp_read && !(temp_busy_o && temp_conv_done) |=> !flags_o.temp_done)
		else $error("temperature flag not cleared by read");

	a_fifo_cap: assert property (@(posedge clk) disable iff (!rstn)
		fifo_count_o <= FIFO_FULL)
		else $error("FIFO count above capacity");

	a_af_clear: assert property (@(posedge clk) disable iff (!rstn)
		fifo_read && !new_sample |=> !flags_o.almost_full)
		else $error("almost-full not cleared by FIFO read");

	a_intr_level: assert property (@(posedge clk) disable iff (!rstn)
		intr_oe_o == |(flags_o & $past(irq_en)))
		else $error("interrupt pin disagrees with pending flags");

	a_intr_low: assert property (@(posedge clk) disable iff (!rstn)
		intr_oe_o |-> !intr_o)
		else $error("interrupt pin driven high");

	a_intr_data_zero: assert property (@(posedge clk) disable iff (!rstn)
		!intr_o)
		else $error("interrupt data not held low");

	// ----------------------------------------------------------------
	// Temperature sequencing checks
	// ----------------------------------------------------------------
	a_busy_on_start: assert property (@(posedge clk) disable iff (!rstn)
		!temp_busy_o && temp_start |=> temp_busy_o && temp_conv_start_o)
		else $error("temperature command not taken");

	a_conv_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
		temp_conv_start_o |=> !temp_conv_start_o)
		else $error("conversion start longer than one cycle");

	a_busy_hold: assert property (@(posedge clk) disable iff (!rstn)
		temp_busy_o && !temp_conv_done |=> temp_busy_o)
		else $error("start bit cleared before conversion end");

	a_temp_capture: assert property (@(posedge clk) disable iff (!rstn)
		temp_busy_o && temp_conv_done |=> (temp_o == $past(temp_conv_value)))
		else $error("temperature result not captured");

	a_temp_hold: assert property (@(posedge clk) disable iff (!rstn)
		!(temp_busy_o && temp_conv_done) |=> $stable(temp_o))
		else $error("temperature result changed without conversion");

	a_temp_set_wins: assert property (@(posedge clk) disable iff (!rstn)
		temp_read && temp_busy_o && temp_conv_done |=> flags_o.temp_done)
		else $error("temperature-done lost to a read");

	a_temp_flag_hold: assert property (@(posedge clk) disable iff (!rstn)
		!temp_read && !(temp_busy_o && temp_conv_done) |=> $stable(flags_o.temp_done))
		else $error("temperature-done changed without cause");

	// ----------------------------------------------------------------
	// LED timing checks
	// ----------------------------------------------------------------
	a_dark_idle: assert property (@(posedge clk) disable iff (!rstn)
		($past(cfg.mode) != MODE_SINGLE) && ($past(cfg.mode) != MODE_DUAL)
			|-> !red_led_o && !ir_led_o)
		else $error("LED lit while idle");

	a_red_start: assert property (@(posedge clk) disable iff (!rstn)
		$rose(red_led_o) && $stable(cfg) |-> ($past(st_reg.period_cnt) == '0))
		else $error("red pulse not at period start");

	// ----------------------------------------------------------------
	// FIFO checks
	// ----------------------------------------------------------------
	a_count_push: assert property (@(posedge clk) disable iff (!rstn)
		push_ok && !pop |=> (fifo_count_o == $past(fifo_count_o) + 6'h01))
		else $error("count not raised by push");

	a_count_pop: assert property (@(posedge clk) disable iff (!rstn)
		pop && !push_ok |=> (fifo_count_o == $past(fifo_count_o) - 6'h01))
		else $error("count not lowered by read");

	a_full_hold: assert property (@(posedge clk) disable iff (!rstn)
		(fifo_count_o == FIFO_FULL) && !fifo_read |=> (fifo_count_o == FIFO_FULL))
		else $error("full FIFO count changed without read");

	a_empty_hold: assert property (@(posedge clk) disable iff (!rstn)
		(fifo_count_o == 6'h00) && !new_sample |=> (fifo_count_o == 6'h00))
		else $error("empty FIFO count changed without sample");

	a_rdy_set: assert property (@(posedge clk) disable iff (!rstn)
		push_ok |=> flags_o.sample_rdy)
		else $error("stored sample not flagged");

	a_rdy_clear: assert property (@(posedge clk) disable iff (!rstn)
		fifo_read && !push_ok |=> !flags_o.sample_rdy)
		else $error("sample flag not cleared by read");

	a_rdy_hold: assert property (@(posedge clk) disable iff (!rstn)
		!fifo_read && !push_ok |=> $stable(flags_o.sample_rdy))
		else $error("sample flag changed without cause");

	// Either way the count after the push is at least the level
	a_af_set: assert property (@(posedge clk) disable iff (!rstn)
		push_ok && (fifo_count_o >= cfg.af_level) |=> flags_o.almost_full)
		else $error("almost-full not raised at level");

	a_af_hold: assert property (@(posedge clk) disable iff (!rstn)
		!fifo_read && !push_ok |=> $stable(flags_o.almost_full))
		else $error("almost-full changed without cause");

	a_head_write: assert property (@(posedge clk) disable iff (!rstn)
		push_ok && (fifo_count_o == 6'h00) |=> (fifo_head_o == $past(lk_reg.hold)))
		else $error("sample into drained FIFO not at head");

	a_head_stable: assert property (@(posedge clk) disable iff (!rstn)
		!pop && !(push_ok && (fifo_count_o == 6'h00)) |=> $stable(fifo_head_o))
		else $error("head changed without read");

endmodule : optical_acquisition_sequencer

// ==== verif/acq_far_model.sv ====
`timescale 1ns/1ps
module acq_far_model
	import acq_pkg::*;
#(
	parameter int LAT = 20
) (
	input wire logic clk,
	input wire logic adc_clk,
	input wire logic rstn,
	input wire logic send_tgl,
	input wire sample_t send_val,
	input wire temp_t temp_val,
	input wire logic conv_start,
	output logic adc_valid,
	output sample_t adc_sample,
	output logic conv_done,
	output temp_t conv_value
);
	// ----------------------------------------
	// Converter side of the sample link
	// ----------------------------------------
	logic [2:0] tg;
	int cnt;
	always_ff @(posedge adc_clk or negedge rstn) begin
		if (!rstn) begin
			tg <= '0;
			adc_valid <= 1'b0;
			adc_sample <= '0;
		end else begin
			tg <= {tg[1:0], send_tgl};
			adc_valid <= tg[2] ^ tg[1];
			// Data is scrambled outside the valid cycle so stale values cannot pass
			adc_sample <= (tg[2] ^ tg[1]) ? send_val : ~adc_sample;
		end
	end
	// ----------------------------------------
	// Die temperature converter
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			conv_done <= 1'b0;
			conv_value <= '0;
		end else begin
			conv_done <= 1'b0;
			conv_value <= ~conv_value;
			if (conv_start) begin
				cnt <= LAT;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end else if (cnt == 1) begin
				cnt <= 0;
				conv_done <= 1'b1;
				conv_value <= temp_val;
			end
		end
	end
endmodule : acq_far_model

// ==== verif/optical_acquisition_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module optical_acquisition_sequencer_tb_top;
	import acq_pkg::*;
	localparam tab8_t PER = '{400, 300, 250, 200, 150, 120, 100, 80};
	localparam tab4_t PWC = '{4, 6, 8, 10};
	localparam tab4_t SPC = '{20, 26, 33, 45};
	logic clk, adc_clk, rstn, temp_start, temp_read, fifo_read, send_tgl;
	logic adc_valid, conv_done, conv_start, red_led_o, ir_led_o, temp_busy_o, intr_o, intr_oe_o;
	acq_cfg_t cfg;
	irq_t irq_en, flags_o;
	sample_t send_val, adc_sample, fifo_head_o;
	temp_t tval, conv_value, temp_o;
	logic [4:0] adc_res_o;
	logic [5:0] fifo_count_o;
	logic [15:0] rnd = 16'hA2B3;
	int fails = 0;
	int check_count = 0;
	optical_acquisition_sequencer #(.PERIOD_CYC(PER), .PW_CYC(PWC), .SPACE_CYC(SPC)) uut (
		.clk(clk), .rstn(rstn), .cfg(cfg), .irq_en(irq_en), .temp_start(temp_start),
		.temp_read(temp_read), .fifo_read(fifo_read), .temp_conv_done(conv_done),
		.temp_conv_value(conv_value), .adc_clk(adc_clk), .adc_valid(adc_valid),
		.adc_sample(adc_sample), .red_led_o(red_led_o), .ir_led_o(ir_led_o),
		.adc_res_o(adc_res_o), .temp_busy_o(temp_busy_o), .temp_conv_start_o(conv_start),
		.temp_o(temp_o), .fifo_head_o(fifo_head_o), .fifo_count_o(fifo_count_o),
		.flags_o(flags_o), .intr_o(intr_o), .intr_oe_o(intr_oe_o));
	acq_far_model far (.clk(clk), .adc_clk(adc_clk), .rstn(rstn), .send_tgl(send_tgl),
		.send_val(send_val), .temp_val(tval), .conv_start(conv_start), .adc_valid(adc_valid),
		.adc_sample(adc_sample), .conv_done(conv_done), .conv_value(conv_value));
	always #5 clk = ~clk;
	initial begin
		adc_clk = 1'b0;
		#2.3;
		forever #6 adc_clk = ~adc_clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	function automatic bit legal(input logic [2:0] m, input logic [1:0] p, input logic [2:0] r);
		if (m == MODE_DUAL) return r < 4 || (r == 4 && p < 3) || (r == 5 && p < 2) || (r == 6 && p == 0);
		return r < 6 || (r == 6 && p < 3) || (r == 7 && p == 0);
	endfunction : legal
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic push(output sample_t s);
		rnd = lfsr(rnd);
		s = {rnd[0], 2'b00, rnd};
		@(posedge clk);
		send_val <= s;
		send_tgl <= ~send_tgl;
		repeat (30) @(posedge clk);
		@(negedge clk);
	endtask : push
	task automatic rd();
		@(posedge clk);
		fifo_read <= 1'b1;
		@(posedge clk);
		fifo_read <= 1'b0;
		@(negedge clk);
	endtask : rd
	task automatic seq(input logic [2:0] m, input logic [1:0] p);
		int t, rw, sp, pr, both;
		logic [2:0] r;
		r = 3'h0;
		for (int k = 0; k < 8; k++) begin
			rnd = lfsr(rnd);
			if (legal(m, p, rnd[2:0])) r = rnd[2:0];
		end
		@(posedge clk);
		cfg.mode <= 3'h0;
		repeat (3) @(posedge clk);
		cfg <= '{m, p, r, 6'h1F};
		{t, rw, sp, pr, both} = '0;
		while (red_led_o !== 1'b1 && t < 500) begin
			@(negedge clk);
			t++;
		end
		if (t >= 500) chk("red_start", 1, 0);
		for (t = 1; t < 460; t++) begin
			@(negedge clk);
			if (!red_led_o && rw == 0) rw = t;
			if (red_led_o && rw != 0 && pr == 0) pr = t;
			if (ir_led_o && sp == 0) sp = t;
			if (red_led_o && ir_led_o) both++;
		end
		chk("red_width", PWC[p], rw);
		chk("ir_space", m == MODE_DUAL ? SPC[p] : 0, sp);
		chk("period", PER[r], pr);
		chk("overlap", 0, both);
		chk("resolution", 15 + p, adc_res_o);
	endtask : seq
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int i, cs;
		sample_t s;
		temp_t tv;
		sample_t q[$];
		clk = 1'b0;
		rstn = 1'b0;
		{cfg, irq_en, temp_start, temp_read, fifo_read, send_tgl, send_val, tval} = '0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("rst_count", 0, fifo_count_o);
		chk("rst_oe", 0, intr_oe_o);
		for (i = 0; i < 8; i++) seq(i[0] ? MODE_SINGLE : MODE_DUAL, i[2:1]);
		@(posedge clk);
		cfg.mode <= 3'h0;
		irq_en <= 3'h1;
		cs = 0;
		repeat (60) begin
			@(negedge clk);
			cs += conv_start;
		end
		chk("no_conv", 0, cs);
		rnd = lfsr(rnd);
		tv = {rnd[7:0] | 8'h80, rnd[11:8]};
		@(posedge clk);
		tval <= tv;
		cfg.mode <= MODE_DUAL;
		temp_start <= 1'b1;
		@(posedge clk);
		temp_start <= 1'b0;
		repeat (3) @(posedge clk);
		temp_start <= 1'b1;
		@(posedge clk);
		temp_start <= 1'b0;
		repeat (60) begin
			@(negedge clk);
			cs += conv_start;
		end
		chk("busy_refuse", 0, cs);
		chk("busy_clear", 0, temp_busy_o);
		chk("temp_value", tv, temp_o);
		chk("temp_flag", 1, flags_o.temp_done);
		chk("intr_oe", 1, intr_oe_o);
		chk("intr_pin", 0, intr_o);
		@(posedge clk);
		temp_read <= 1'b1;
		@(posedge clk);
		temp_read <= 1'b0;
		@(negedge clk);
		@(negedge clk);
		chk("temp_flag_clr", 0, flags_o.temp_done);
		chk("intr_release", 0, intr_oe_o);
		@(posedge clk);
		irq_en <= 3'h2;
		cfg.af_level <= 6'h1F;
		for (i = 1; i <= 33; i++) begin
			push(s);
			if (i <= 32) q.push_back(s);
			chk("count", i > 32 ? 32 : i, fifo_count_o);
			chk("almost_full", i >= 31, flags_o.almost_full);
			chk("af_intr", i >= 31, intr_oe_o);
		end
		chk("sample_rdy", 1, flags_o.sample_rdy);
		chk("head", q.pop_front(), fifo_head_o);
		rd();
		@(negedge clk);
		chk("count_rd", 31, fifo_count_o);
		chk("af_clear", 0, flags_o.almost_full);
		chk("af_intr_clr", 0, intr_oe_o);
		push(s);
		q.push_back(s);
		chk("count_refill", 32, fifo_count_o);
		while (q.size() > 0) begin
			chk("head", q.pop_front(), fifo_head_o);
			rd();
		end
		chk("count_empty", 0, fifo_count_o);
		rd();
		chk("empty_read", 0, fifo_count_o);
		complete_run();
	end
endmodule : optical_acquisition_sequencer_tb_top
